// *** inc/xfx_defines.vh ***
// Constants for the exclusive-OR and extended instruction decoder
// Operation
// (RULE1) Opcode 0001 10da ffffffff is xor_accum_with_file, one instruction cycle.
// (RULE2) Result is accumulator XOR addressed file register.
// (RULE3) Destination bit 0 writes accumulator, 1 writes file register back.
// (RULE4) Exclusive-OR updates only negative and zero flags.
// (RULE5) Bank bit 0 selects access bank, 1 uses bank select register.
// (RULE6) Bank 0, extension on, address at most 5Fh: indexed literal offset.
// (RULE7) Extension and indexed mode stay off unless the enable bit is set.
// (RULE8) Extension adds eight instructions, none affecting status flags.
// (RULE9) 1110 1000/1001 ffkkkkkk add or subtract literal to selected pointer.
// (RULE10) Pointer field 11 uses stack pointer then returns, two cycles.
// (RULE11) Pointer-and-return loads PC from return stack top, second cycle idle.
// (RULE12) Opcode 0014h is call via accumulator, two cycles.
// (RULE13) Call pushes next address, PC low from accumulator, high/upper from latches.
// (RULE14) 1110 1011 two-word moves; bit 7 picks file or indexed destination.
// (RULE15) 1110 1010 kkkkkkkk stores literal at stack pointer then decrements it.
// (RULE16) With extension off, extended opcodes are unimplemented and change nothing.
`ifndef XFX_DEFINES_VH
`define XFX_DEFINES_VH
`define XFX_OP_XOR_FILE_HI 6'h06
`define XFX_OP_PTR_ADD    8'hE8
`define XFX_OP_PTR_SUB    8'hE9
`define XFX_OP_PUSH_LIT   8'hEA
`define XFX_OP_MOVE_IDX   8'hEB
`define XFX_OP_CALL_ACC   16'h0014
`define XFX_SECOND_NIB    4'hF
`define XFX_IDX_LIMIT     8'h5F
`define XFX_STACK_PTR_SEL 2'h3
`define XFX_ACCESS_HI_BNK 4'hF
`define XFX_ACCESS_SPLIT  8'h80
`define XFX_PTR_RST       12'h000
`define XFX_PHASES        2'h3
`endif

// *** rtl/xfx_phase_gen.v ***
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`include "xfx_defines.vh"
module xfx_phase_gen (
    clk_sys,
    sys_rst,
    phase_q,
    cycle_end_q
);
    input            clk_sys;
    input            sys_rst;
    output reg [1:0] phase_q;
    output reg       cycle_end_q;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            phase_q     <= 2'h0;
            cycle_end_q <= 1'b0;
        end else begin
            phase_q     <= phase_q + 2'h1;
            cycle_end_q <= (phase_q == (`XFX_PHASES - 2'h1));
        end
    end
endmodule

// *** rtl/xfx_decoder.v ***
// Decoder and executor for the exclusive-OR-with-file and extended instructions
`timescale 1ns/1ps
`include "xfx_defines.vh"
module xfx_decoder (
    clk_sys,
    sys_rst,
    instr_word,
    instr_valid,
    extension_enable_cfg,
    accumulator_in,
    file_rd_data,
    bank_select_reg,
    top_of_return_stack,
    pc_next_in,
    pc_high_latch,
    pc_upper_latch,
    instr_take_q,
    file_rd_addr_q,
    indexed_mode_q,
    wr_accum_q,
    wr_file_q,
    wr_addr_q,
    wr_data_q,
    flag_n_q,
    flag_z_q,
    flag_we_q,
    pc_load_q,
    pc_load_val_q,
    stack_push_q,
    stack_push_val_q,
    stack_pop_q,
    file_pointer0_q,
    file_pointer1_q,
    software_stack_pointer_q,
    unimpl_q,
    busy_q
);
    input             clk_sys;
    input             sys_rst;
    input      [15:0] instr_word;
    input             instr_valid;
    input             extension_enable_cfg;
    input      [7:0]  accumulator_in;
    input      [7:0]  file_rd_data;
    input      [3:0]  bank_select_reg;
    input      [20:0] top_of_return_stack;
    input      [20:0] pc_next_in;
    input      [7:0]  pc_high_latch;
    input      [7:0]  pc_upper_latch;
    output reg        instr_take_q;
    output reg [11:0] file_rd_addr_q;
    output reg        indexed_mode_q;
    output reg        wr_accum_q;
    output reg        wr_file_q;
    output reg [11:0] wr_addr_q;
    output reg [7:0]  wr_data_q;
    output reg        flag_n_q;
    output reg        flag_z_q;
    output reg        flag_we_q;
    output reg        pc_load_q;
    output reg [20:0] pc_load_val_q;
    output reg        stack_push_q;
    output reg [20:0] stack_push_val_q;
    output reg        stack_pop_q;
    output reg [11:0] file_pointer0_q;
    output reg [11:0] file_pointer1_q;
    output reg [11:0] software_stack_pointer_q;
    output reg        unimpl_q;
    output reg        busy_q;

    // ********************************************
    // Phase timing and state
    // ********************************************
    localparam ST_IDLE  = 2'h0;
    localparam ST_NOP   = 2'h1;
    localparam ST_WORD2 = 2'h2;

    wire [1:0]  phase_q;
    wire        cycle_end_q;
    reg  [1:0]  state_q;
    reg  [15:0] ir_q;
    reg         ext_en_q;
    reg         ext_en_d;
    reg  [11:0] move_src_q;

    xfx_phase_gen u_phase (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .phase_q     (phase_q),
        .cycle_end_q (cycle_end_q)
    );

    // Direct or indexed operand address
    function [11:0] xfx_file_addr;
        input [7:0]  f;
        input        a;
        input [3:0]  bank;
        input        ext;
        input [11:0] sp;
        begin
            if (!a && ext && f <= `XFX_IDX_LIMIT)
                xfx_file_addr = sp + {4'h0, f};                        // [RULE6]
            else if (a)
                xfx_file_addr = {bank, f};                             // [RULE5]
            else if (f < `XFX_ACCESS_SPLIT)
                xfx_file_addr = {4'h0, f};
            else
                xfx_file_addr = {`XFX_ACCESS_HI_BNK, f};
        end
    endfunction

    function [11:0] xfx_ptr_sel;
        input [1:0]  sel;
        input [11:0] p0;
        input [11:0] p1;
        input [11:0] p2;
        begin
            case (sel)
                2'h0:    xfx_ptr_sel = p0;
                2'h1:    xfx_ptr_sel = p1;
                default: xfx_ptr_sel = p2;
            endcase
        end
    endfunction

    wire        is_xor   = (ir_q[15:10] == `XFX_OP_XOR_FILE_HI);      // [RULE1]
    wire        is_add   = (ir_q[15:8] == `XFX_OP_PTR_ADD);
    wire        is_sub   = (ir_q[15:8] == `XFX_OP_PTR_SUB);
    wire        is_push  = (ir_q[15:8] == `XFX_OP_PUSH_LIT);
    wire        is_move  = (ir_q[15:8] == `XFX_OP_MOVE_IDX);
    wire        is_call_acc = (ir_q == `XFX_OP_CALL_ACC);               // [RULE12]
    wire        is_ext   = is_add | is_sub | is_push | is_move | is_call_acc; // [RULE8]
    wire [11:0] lit6     = {6'h00, ir_q[5:0]};
    wire [1:0]  psel     = ir_q[7:6];
    wire [11:0] ptr_cur  = xfx_ptr_sel(psel, file_pointer0_q, file_pointer1_q, software_stack_pointer_q);
    wire [11:0] ptr_new  = is_add ? ptr_cur + lit6 : ptr_cur - lit6;   // [RULE9]
    wire [7:0]  xor_res  = accumulator_in ^ file_rd_data;             // [RULE2]

    // ********************************************
    // Execution
    // ********************************************
    always @* begin
        ext_en_d = ext_en_q;
        if (sys_rst)
            ext_en_d = 1'b0;
        else
            ext_en_d = extension_enable_cfg;                            // [RULE7]
    end

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q                  <= ST_IDLE;
            ir_q                     <= 16'h0000;
            ext_en_q                 <= 1'b0;
            move_src_q               <= 12'h000;
            instr_take_q             <= 1'b0;
            file_rd_addr_q           <= 12'h000;
            indexed_mode_q           <= 1'b0;
            wr_accum_q               <= 1'b0;
            wr_file_q                <= 1'b0;
            wr_addr_q                <= 12'h000;
            wr_data_q                <= 8'h00;
            flag_n_q                 <= 1'b0;
            flag_z_q                 <= 1'b0;
            flag_we_q                <= 1'b0;
            pc_load_q                <= 1'b0;
            pc_load_val_q            <= 21'h000000;
            stack_push_q             <= 1'b0;
            stack_push_val_q         <= 21'h000000;
            stack_pop_q              <= 1'b0;
            file_pointer0_q          <= `XFX_PTR_RST;
            file_pointer1_q          <= `XFX_PTR_RST;
            software_stack_pointer_q <= `XFX_PTR_RST;
            unimpl_q                 <= 1'b0;
            busy_q                   <= 1'b0;
        end else begin
            ext_en_q     <= ext_en_d;
            instr_take_q <= 1'b0;
            wr_accum_q   <= 1'b0;
            wr_file_q    <= 1'b0;
            flag_we_q    <= 1'b0;
            pc_load_q    <= 1'b0;
            stack_push_q <= 1'b0;
            stack_pop_q  <= 1'b0;
            unimpl_q     <= 1'b0;
            // Q1: fetch and decode
            if (phase_q == 2'h0) begin
                if (state_q == ST_IDLE && instr_valid) begin
                    ir_q         <= instr_word;
                    instr_take_q <= 1'b1;
                    busy_q       <= 1'b1;
                    file_rd_addr_q <= xfx_file_addr(instr_word[7:0], instr_word[8], bank_select_reg,
                                                    ext_en_q, software_stack_pointer_q);
                    indexed_mode_q <= !instr_word[8] && ext_en_q && instr_word[7:0] <= `XFX_IDX_LIMIT;
                end else if (state_q == ST_WORD2 && instr_valid) begin
                    instr_take_q <= 1'b1;
                    // Second word of the two-word move
                    if (instr_word[15:12] == `XFX_SECOND_NIB) begin                // [RULE14]
                        file_rd_addr_q <= move_src_q;
                        wr_addr_q      <= ir_q[7] ? software_stack_pointer_q + {5'h00, instr_word[6:0]}
                                                  : instr_word[11:0];
                    end else begin
                        // Bad second word aborts the move, nothing written
                        unimpl_q <= 1'b1;
                        state_q  <= ST_IDLE;
                        busy_q   <= 1'b0;
                    end
                end
            end
            // Q4: write back at end of instruction cycle
            if (cycle_end_q && busy_q) begin
                case (state_q)
                    ST_IDLE: begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                        if (is_xor) begin
                            wr_data_q  <= xor_res;
                            wr_addr_q  <= file_rd_addr_q;
                            wr_accum_q <= !ir_q[9];                             // [RULE3]
                            wr_file_q  <= ir_q[9];                              // [RULE3]
                            flag_n_q   <= xor_res[7];                           // [RULE4]
                            flag_z_q   <= (xor_res == 8'h00);                   // [RULE4]
                            flag_we_q  <= 1'b1;
                        end else if (is_ext && !ext_en_q) begin
                            unimpl_q <= 1'b1;                                   // [RULE16]
                        end else if (is_add || is_sub) begin
                            case (psel)
                                2'h0:    file_pointer0_q <= ptr_new;
                                2'h1:    file_pointer1_q <= ptr_new;
                                default: software_stack_pointer_q <= ptr_new;
                            endcase
                            if (psel == `XFX_STACK_PTR_SEL) begin               // [RULE10]
                                pc_load_q     <= 1'b1;
                                pc_load_val_q <= top_of_return_stack;           // [RULE11]
                                stack_pop_q   <= 1'b1;
                                state_q       <= ST_NOP;
                                busy_q        <= 1'b1;
                            end
                        end else if (is_push) begin
                            wr_file_q                <= 1'b1;                   // [RULE15]
                            wr_addr_q                <= software_stack_pointer_q;
                            wr_data_q                <= ir_q[7:0];
                            software_stack_pointer_q <= software_stack_pointer_q - 12'h001;
                        end else if (is_call_acc) begin
                            stack_push_q     <= 1'b1;                           // [RULE13]
                            stack_push_val_q <= pc_next_in;
                            pc_load_q        <= 1'b1;
                            pc_load_val_q    <= {pc_upper_latch[4:0], pc_high_latch, accumulator_in};
                            state_q          <= ST_NOP;
                            busy_q           <= 1'b1;
                        end else if (is_move) begin
                            move_src_q <= (ir_q[7] ? software_stack_pointer_q : software_stack_pointer_q)
                                          + {5'h00, ir_q[6:0]};                 // [RULE14]
                            state_q    <= ST_WORD2;
                            busy_q     <= 1'b1;
                        end
                    end
                    ST_NOP: begin
                        state_q <= ST_IDLE;                                     // [RULE11]
                        busy_q  <= 1'b0;
                    end
                    ST_WORD2: begin
                        wr_file_q <= 1'b1;
                        wr_data_q <= file_rd_data;
                        state_q   <= ST_IDLE;
                        busy_q    <= 1'b0;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// *** tb/xfx_props.sv ***
// Checker for the exclusive-OR and extended instruction decoder
`timescale 1ns/1ps
module xfx_props (
    input logic        clk_sys,
    input logic        sys_rst,
    input logic [15:0] instr_word,
    input logic        extension_enable_cfg,
    input logic [7:0]  accumulator_in,
    input logic [3:0]  bank_select_reg,
    input logic [20:0] top_of_return_stack,
    input logic [20:0] pc_next_in,
    input logic [7:0]  pc_high_latch,
    input logic [7:0]  pc_upper_latch,
    input logic        instr_take_q,
    input logic [11:0] file_rd_addr_q,
    input logic        wr_accum_q,
    input logic        wr_file_q,
    input logic [7:0]  wr_data_q,
    input logic        flag_n_q,
    input logic        flag_z_q,
    input logic        flag_we_q,
    input logic        pc_load_q,
    input logic [20:0] pc_load_val_q,
    input logic        stack_push_q,
    input logic [20:0] stack_push_val_q,
    input logic [11:0] software_stack_pointer_q,
    input logic        unimpl_q
);
    // ****************************************
    // Word seen at the accepting edge
    // ****************************************
    logic [15:0] word_q;
    logic [3:0]  bank_q;
    logic [11:0] sp_q;
    logic        ext_q;
    always @(posedge clk_sys) begin
        word_q <= instr_word;
        bank_q <= bank_select_reg;
        sp_q   <= software_stack_pointer_q;
        ext_q  <= extension_enable_cfg;
    end
    wire xt = instr_take_q && word_q[15:10] == 6'h06;
    wire et = instr_take_q && ext_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    xor_dest_a: assert property (xt |-> ##3 wr_file_q == $past(word_q[9], 3) && wr_accum_q != $past(word_q[9], 3))
        else $error("xor destination write wrong");
    xor_one_cycle_a: assert property (xt |-> ##3 flag_we_q && (wr_file_q || wr_accum_q))
        else $error("xor did not finish in one instruction cycle");
    flag_zero_a: assert property (flag_we_q |-> flag_z_q == (wr_data_q == 8'h00))
        else $error("zero flag wrong");
    flag_neg_a: assert property (flag_we_q |-> flag_n_q == wr_data_q[7])
        else $error("negative flag wrong");
    bank_sel_a: assert property (xt && word_q[8] |-> file_rd_addr_q == {bank_q, word_q[7:0]})
        else $error("banked address wrong");
    access_high_a: assert property (xt && !word_q[8] && word_q[7] |-> file_rd_addr_q == {4'hF, word_q[7:0]})
        else $error("access bank address wrong");
    idx_addr_a: assert property (xt && ext_q && !word_q[8] && word_q[7:0] <= 8'h5F
        |-> file_rd_addr_q == sp_q + {4'h0, word_q[7:0]}) else $error("indexed address wrong");
    ret_load_a: assert property (et && word_q[15:9] == 7'h74 && word_q[7:6] == 2'h3
        |-> ##3 pc_load_q && pc_load_val_q == top_of_return_stack) else $error("return load wrong");
    call_push_a: assert property (et && word_q == 16'h0014 |-> ##3 stack_push_q
        && stack_push_val_q == pc_next_in && pc_load_val_q == {pc_upper_latch[4:0], pc_high_latch, accumulator_in})
        else $error("call via accumulator wrong");
    ext_noflag_a: assert property (instr_take_q && word_q[15:12] == 4'hE |-> ##3 !flag_we_q)
        else $error("extended op touched flags");
    unimpl_quiet_a: assert property (unimpl_q |-> !pc_load_q && !stack_push_q && !wr_file_q
        && $stable(software_stack_pointer_q)) else $error("unimplemented op changed state");
endmodule
bind xfx_decoder xfx_props u_props (.clk_sys, .sys_rst, .instr_word, .extension_enable_cfg, .accumulator_in,
    .bank_select_reg, .top_of_return_stack, .pc_next_in, .pc_high_latch, .pc_upper_latch, .instr_take_q,
    .file_rd_addr_q, .wr_accum_q, .wr_file_q, .wr_data_q, .flag_n_q, .flag_z_q, .flag_we_q, .pc_load_q,
    .pc_load_val_q, .stack_push_q, .stack_push_val_q, .software_stack_pointer_q, .unimpl_q);

// *** tb/tb.sv ***
// Self-checking bench for the exclusive-OR and extended instruction decoder
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 0, sys_rst = 1, instr_valid = 0, extension_enable_cfg = 0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0]  accumulator_in = 8'h00, file_rd_data = 8'h00, pc_high_latch = 8'h10, pc_upper_latch = 8'h02;
    logic [3:0]  bank_select_reg = 4'h3;
    logic [20:0] top_of_return_stack = 21'h012344, pc_next_in = 21'h000106;
    logic        instr_take_q, wr_accum_q, wr_file_q, flag_n_q, flag_z_q, flag_we_q, pc_load_q, stack_push_q, unimpl_q;
    logic        indexed_mode_q, stack_pop_q, busy_q;
    logic [11:0] file_rd_addr_q, wr_addr_q, file_pointer0_q, file_pointer1_q, software_stack_pointer_q;
    logic [7:0]  wr_data_q, d;
    logic [20:0] pc_load_val_q, stack_push_val_q;
    logic [15:0] w;
    logic [11:0] a;
    logic        wf;
    int          err_total = 0, compares = 0;
    localparam logic [44:0] ROWS [4] = '{{16'h1A10, 8'hB5, 8'hAF, 12'h010, 1'b1}, {16'h1885, 8'hB5, 8'hAF, 12'hF85, 1'b0},
        {16'h1B22, 8'hB5, 8'hAF, 12'h322, 1'b1}, {16'h1A50, 8'hAF, 8'hAF, 12'h050, 1'b1}};
    xfx_decoder u_dut (.clk_sys, .sys_rst, .instr_word, .instr_valid, .extension_enable_cfg, .accumulator_in,
        .file_rd_data, .bank_select_reg, .top_of_return_stack, .pc_next_in, .pc_high_latch, .pc_upper_latch,
        .instr_take_q, .file_rd_addr_q, .indexed_mode_q, .wr_accum_q, .wr_file_q, .wr_addr_q, .wr_data_q,
        .flag_n_q, .flag_z_q, .flag_we_q, .pc_load_q, .pc_load_val_q, .stack_push_q, .stack_push_val_q,
        .stack_pop_q, .file_pointer0_q, .file_pointer1_q, .software_stack_pointer_q, .unimpl_q, .busy_q);
    always #2.5 clk_sys = ~clk_sys;
    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic do_reset;
        @(negedge clk_sys);
        sys_rst = 1;
        repeat (12) @(negedge clk_sys);
        sys_rst = 0;
        repeat (8) @(negedge clk_sys);
    endtask
    // Present a word, wait for its take, land just after its result edge
    task automatic run(input logic [15:0] word);
        int n;
        n = 0;
        @(negedge clk_sys);
        instr_word = word;
        instr_valid = 1;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (instr_take_q !== 1'b1 && n < 40);
        if (n >= 40) chk(instr_take_q, 1'b1);
        @(negedge clk_sys);
        instr_valid = 0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    initial begin
        #20000;
        err_total++;
        print_verdict;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        do_reset;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            {w, accumulator_in, file_rd_data, a, wf} = ROWS[i];
            run(w);
            d = accumulator_in ^ file_rd_data;
            chk({indexed_mode_q, file_rd_addr_q}, {1'b0, a});
            chk(wr_data_q, d);
            chk({wr_file_q, wr_accum_q, flag_we_q, busy_q}, {wf, !wf, 1'b1, 1'b0});
            chk({flag_n_q, flag_z_q}, {d[7], d == 8'h00});
        end
        run(16'hE8A3);
        chk({unimpl_q, pc_load_q, wr_file_q, software_stack_pointer_q}, {3'b100, 12'h000});
        @(negedge clk_sys);
        extension_enable_cfg = 1;
        do_reset;
        chk(software_stack_pointer_q, 12'h000);
        run(16'hE8A3);
        chk(software_stack_pointer_q, 12'h023);
        run(16'hE901);
        chk({flag_we_q, file_pointer0_q}, {1'b0, 12'hFFF});
        run(16'hE845);
        chk(file_pointer1_q, 12'h005);
        run(16'h1A10);
        chk({indexed_mode_q, file_rd_addr_q}, {1'b1, 12'h033});
        run(16'hEA5A);
        chk({wr_file_q, wr_addr_q, wr_data_q}, {1'b1, 12'h023, 8'h5A});
        chk(software_stack_pointer_q, 12'h022);
        run(16'hE8C4);
        chk({pc_load_q, stack_pop_q, busy_q, pc_load_val_q}, {3'b111, top_of_return_stack});
        chk(software_stack_pointer_q, 12'h026);
        run(16'hE9C6);
        chk(software_stack_pointer_q, 12'h020);
        run(16'h0014);
        chk({stack_push_q, stack_push_val_q}, {1'b1, pc_next_in});
        chk(pc_load_val_q, {pc_upper_latch[4:0], pc_high_latch, accumulator_in});
        run(16'hEB05);
        run(16'hF123);
        chk({wr_file_q, wr_addr_q, flag_we_q}, {1'b1, 12'h123, 1'b0});
        run(16'hEB85);
        run(16'hF083);
        chk({wr_file_q, wr_addr_q, file_rd_addr_q}, {1'b1, 12'h023, 12'h025});
        print_verdict;
    end
endmodule
